// ==== hdl/cim_pkg.sv ====
// constants, register map and carrier types of the codec input/mix bank
package cim_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0]  CIM_IDX_CODEC_STATUS   = 6'h00;
   localparam logic [5:0]  CIM_IDX_CHANNEL_FLAGS  = 6'h01;
   localparam logic [5:0]  CIM_IDX_ADC_INPUT      = 6'h02;
   localparam logic [5:0]  CIM_IDX_DAC2_MIX       = 6'h03;
   localparam logic [5:0]  CIM_IDX_AUX1_MIX       = 6'h04;
   localparam logic [5:0]  CIM_IDX_AUX2_MIX       = 6'h05;
   localparam logic [5:0]  CIM_IDX_CHANNEL_ENABLE = 6'h1B;
   localparam logic [5:0]  CIM_IDX_POWER_CTRL     = 6'h1C;

   // reset values
   localparam logic [15:0] CIM_RST_FLAGS     = 16'h0000;
   localparam logic [15:0] CIM_RST_ADC_INPUT = 16'h0000;
   localparam logic [15:0] CIM_RST_MIX       = 16'h8888;
   localparam logic [6:0]  CIM_RST_ENABLE    = 7'h00;
   localparam logic        CIM_RST_PD_REQ    = 1'b1;

   // writable bits of the mixer registers (14:13 and 6:5 reserved)
   localparam logic [15:0] CIM_MIX_WMASK     = 16'h9F9F;

   // channel flag field positions
   localparam int CIM_FLAG_DAC1_UF  = 8;
   localparam int CIM_FLAG_DAC2_UF  = 9;
   localparam int CIM_FLAG_RPEAK_LO = 2;
   localparam int CIM_FLAG_LPEAK_LO = 0;

   // enable register field positions
   localparam int CIM_EN_LEFT_ADC  = 0;
   localparam int CIM_EN_RIGHT_ADC = 1;
   localparam int CIM_EN_DAC1      = 2;
   localparam int CIM_EN_DAC2      = 3;
   localparam int CIM_EN_DDMIX     = 4;
   localparam int CIM_EN_AAMIX     = 5;
   localparam int CIM_EN_ANALOG    = 6;

   // codec status field positions
   localparam int CIM_STAT_PDFLAG  = 14;

   // overrange codes
   localparam logic [1:0] CIM_PEAK_BELOW_M1 = 2'h0;
   localparam logic [1:0] CIM_PEAK_M1_TO_0  = 2'h1;
   localparam logic [1:0] CIM_PEAK_0_TO_P1  = 2'h2;
   localparam logic [1:0] CIM_PEAK_ABOVE_P1 = 2'h3;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } cim_avm_req_s;

   // index 0 = dac1 / left adc, index 1 = dac2 / right adc
   typedef struct packed {
      logic [1:0]       dac_req;
      logic [1:0]       dac_avail;
      logic [1:0][15:0] dac_sample;
      logic [1:0]       adc_peak_valid;
      logic [1:0][1:0]  adc_peak_code;
   } cim_events_s;

   typedef struct packed {
      logic [2:0] left_source_sel;
      logic       left_boost_en;
      logic [3:0] left_input_gain;
      logic [2:0] right_source_sel;
      logic       right_boost_en;
      logic [3:0] right_input_gain;
      logic       left_dactwo_mute;
      logic [4:0] left_dactwo_level;
      logic       right_dactwo_mute;
      logic [4:0] right_dactwo_level;
      logic       left_auxone_mute;
      logic [4:0] left_auxone_level;
      logic       right_auxone_mute;
      logic [4:0] right_auxone_level;
      logic       left_auxtwo_mute;
      logic [4:0] left_auxtwo_level;
      logic       right_auxtwo_mute;
      logic [4:0] right_auxtwo_level;
   } cim_ctl_s;

   typedef struct packed {
      logic [15:0]      adc_input;
      logic [15:0]      dac2_mix;
      logic [15:0]      aux1_mix;
      logic [15:0]      aux2_mix;
      logic [15:0]      flags;
      logic [6:0]       enable;
      logic             pd_req;
      logic             pd_flag;
      logic             ack;
      logic [31:0]      rdata;
      logic [1:0][15:0] dac_out;
   } cim_state_s;

endpackage

// ==== hdl/cim_regs.sv ====
// register bank: adc input control, mixer levels and sticky channel flags
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Contract
// - dac1 empty buffer sets flag, zeros fed
// - dac1 flag sticky until status write/powerdown
// - right peak code sticky max, cleared
// - left peak code same sticky max behaviour
// - peak codes ordered, stored code only rises
// - status zero while reset/pin/converter powered down
// - three-bit source select per adc side
// - boost bit adds twenty dB
// - four-bit input gain, 1.5 dB steps
// - input control default zero, held when down
// - mixer byte top bit is mute, reserved bits
// - five-bit mix level, -1.5 dB steps
// - dac2 mix default 8888, held/blocked conditions
// - aux1 mix default 8888, held/blocked conditions
// - aux1 mix holds per-side mute and level
// - aux2 mix same layout as other mixers
// - dac2 empty buffer sets sticky flag, zeros
// - powered-down flag while pin low or request
module cim_regs
   import cim_pkg::*;
#(
   parameter logic [3:0] REVISION_ID = 4'h5  // arbitrary value
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         power_down_pin_n,
   input  wire cim_avm_req_s avm_req,
   output logic [31:0]       avm_readdata,
   output logic              avm_waitrequest,
   input  wire cim_events_s  events,
   output logic [1:0][15:0]  dac_sample_out,
   output logic              converter_powered_down_flag,
   output cim_ctl_s          ctl
);

   ////////////////////////////////////////////////////////////////////////
   // state
   cim_state_s s_reg;
   cim_state_s s_next;

   logic             req;
   logic             wr_take;
   logic [5:0]       idx;
   logic             aligned;
   logic [15:0]      lane_mask;
   logic             blocked;
   logic             hold_dac2mix;
   logic             hold_mix;
   logic             flag_clear;
   logic [1:0]       dac_en;
   logic [1:0]       adc_en;
   logic [1:0]       uf_cur;
   logic [1:0]       uf_nxt;
   logic [1:0][1:0]  pk_cur;
   logic [1:0][1:0]  pk_nxt;
   logic [1:0][15:0] dac_nxt;

   assign req       = avm_req.read | avm_req.write;
   assign wr_take   = avm_req.write & s_reg.ack;
   assign idx       = avm_req.address[7:2];
   assign aligned   = avm_req.address[1:0] == 2'h0;
   assign lane_mask = {{8{avm_req.byteenable[1]}}, {8{avm_req.byteenable[0]}}};

   // converter-wide hold, from the pin or the registered powered-down flag
   assign blocked = ~power_down_pin_n | s_reg.pd_flag;
   assign hold_dac2mix = blocked | ~s_reg.enable[CIM_EN_DDMIX]
                       | ~s_reg.enable[CIM_EN_DAC2]
                       | ~s_reg.enable[CIM_EN_ANALOG];
   assign hold_mix = blocked | ~s_reg.enable[CIM_EN_AAMIX]
                   | ~s_reg.enable[CIM_EN_ANALOG];

   // any write to the flags register clears, whatever the data
   assign flag_clear = wr_take & aligned
                     & (idx == CIM_IDX_CHANNEL_FLAGS);

   assign dac_en = {s_reg.enable[CIM_EN_DAC2], s_reg.enable[CIM_EN_DAC1]};
   assign adc_en = {s_reg.enable[CIM_EN_RIGHT_ADC],
                    s_reg.enable[CIM_EN_LEFT_ADC]};
   assign uf_cur = {s_reg.flags[CIM_FLAG_DAC2_UF],
                    s_reg.flags[CIM_FLAG_DAC1_UF]};
   assign pk_cur = {s_reg.flags[CIM_FLAG_RPEAK_LO +: 2],
                    s_reg.flags[CIM_FLAG_LPEAK_LO +: 2]};

   ////////////////////////////////////////////////////////////////////////
   // per-channel sticky flags and sample substitution
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_chan
         logic underrun;
         logic [1:0] pk_base;
         assign underrun = events.dac_req[g] & ~events.dac_avail[g];
         // set wins over clear; powerdown forces clear
         assign uf_nxt[g] = dac_en[g]
                          & ((uf_cur[g] & ~flag_clear) | underrun);
         // zero sample in place of missing data
         assign dac_nxt[g] = underrun ? 16'h0000 :
                             events.dac_req[g] ? events.dac_sample[g] :
                             s_reg.dac_out[g];
         assign pk_base = flag_clear ? CIM_PEAK_BELOW_M1 : pk_cur[g];
         // keep the largest code seen
         assign pk_nxt[g] = ~adc_en[g] ? CIM_PEAK_BELOW_M1 :
                            (events.adc_peak_valid[g]
                             && events.adc_peak_code[g] > pk_base) ?
                            events.adc_peak_code[g] : pk_base;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // byte-lane merge of a write into a 16-bit register
   function automatic logic [15:0] merge(input logic [15:0] cur,
                                         input logic [15:0] wd,
                                         input logic [15:0] wmask);
      logic [15:0] m;
      m = wmask;
      merge = (cur & ~m) | (wd & m);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_next = s_reg;
      // one wait cycle, then the answer
      s_next.ack = req & ~s_reg.ack;
      s_next.pd_flag = ~power_down_pin_n | s_reg.pd_req;
      s_next.dac_out = dac_nxt;

      // read data latched in the wait cycle
      if (req && !s_reg.ack) begin
         s_next.rdata = 32'h0000_0000;
         if (aligned) begin
            case (idx)
               CIM_IDX_CODEC_STATUS: begin
                  s_next.rdata[CIM_STAT_PDFLAG] = s_reg.pd_flag;
                  s_next.rdata[3:0] = REVISION_ID;
               end
               CIM_IDX_CHANNEL_FLAGS:  s_next.rdata[15:0] = s_reg.flags;
               CIM_IDX_ADC_INPUT:      s_next.rdata[15:0] = s_reg.adc_input;
               CIM_IDX_DAC2_MIX:       s_next.rdata[15:0] = s_reg.dac2_mix;
               CIM_IDX_AUX1_MIX:       s_next.rdata[15:0] = s_reg.aux1_mix;
               CIM_IDX_AUX2_MIX:       s_next.rdata[15:0] = s_reg.aux2_mix;
               CIM_IDX_CHANNEL_ENABLE: s_next.rdata[6:0]  = s_reg.enable;
               CIM_IDX_POWER_CTRL:     s_next.rdata[0]    = s_reg.pd_req;
               default:                s_next.rdata = 32'h0000_0000;
            endcase
         end
      end

      // writes take effect on the answering edge
      if (wr_take && aligned) begin
         case (idx)
            CIM_IDX_ADC_INPUT:
               s_next.adc_input = merge(s_reg.adc_input,
                  avm_req.writedata[15:0], lane_mask);
            CIM_IDX_DAC2_MIX:
               s_next.dac2_mix = merge(s_reg.dac2_mix,
                  avm_req.writedata[15:0],
                  lane_mask & CIM_MIX_WMASK);
            CIM_IDX_AUX1_MIX:
               s_next.aux1_mix = merge(s_reg.aux1_mix,
                  avm_req.writedata[15:0],
                  lane_mask & CIM_MIX_WMASK);
            CIM_IDX_AUX2_MIX:
               s_next.aux2_mix = merge(s_reg.aux2_mix,
                  avm_req.writedata[15:0],
                  lane_mask & CIM_MIX_WMASK);
            CIM_IDX_CHANNEL_ENABLE: begin
               if (!blocked && avm_req.byteenable[0]) begin
                  s_next.enable = avm_req.writedata[6:0];
               end
            end
            CIM_IDX_POWER_CTRL: begin
               if (avm_req.byteenable[0]) begin
                  s_next.pd_req = avm_req.writedata[0];
               end
            end
            default: s_next.enable = s_next.enable;
         endcase
      end

      // sticky flags; reserved bits stay zero
      s_next.flags = CIM_RST_FLAGS;
      s_next.flags[CIM_FLAG_DAC1_UF] = uf_nxt[0];
      s_next.flags[CIM_FLAG_DAC2_UF] = uf_nxt[1];
      s_next.flags[CIM_FLAG_LPEAK_LO +: 2] = pk_nxt[0];
      s_next.flags[CIM_FLAG_RPEAK_LO +: 2] = pk_nxt[1];

      // held at default and write-blocked
      if (blocked) begin
         s_next.flags = CIM_RST_FLAGS;
         s_next.adc_input = CIM_RST_ADC_INPUT;
      end
      if (hold_dac2mix) begin
         s_next.dac2_mix = CIM_RST_MIX;
      end
      if (hold_mix) begin
         s_next.aux1_mix = CIM_RST_MIX;
         s_next.aux2_mix = CIM_RST_MIX;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_reg.adc_input <= CIM_RST_ADC_INPUT;
         s_reg.dac2_mix  <= CIM_RST_MIX;
         s_reg.aux1_mix  <= CIM_RST_MIX;
         s_reg.aux2_mix  <= CIM_RST_MIX;
         s_reg.flags     <= CIM_RST_FLAGS;
         s_reg.enable    <= CIM_RST_ENABLE;
         s_reg.pd_req    <= CIM_RST_PD_REQ;
         s_reg.pd_flag   <= 1'b1;
         s_reg.ack       <= 1'b0;
         s_reg.rdata     <= 32'h0000_0000;
         s_reg.dac_out   <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign avm_waitrequest = req & ~s_reg.ack;
   assign avm_readdata = s_reg.rdata;
   assign dac_sample_out = s_reg.dac_out;
   assign converter_powered_down_flag = s_reg.pd_flag;

   assign ctl.left_source_sel    = s_reg.adc_input[15:13];
   assign ctl.left_boost_en      = s_reg.adc_input[12];
   assign ctl.left_input_gain    = s_reg.adc_input[11:8];
   assign ctl.right_source_sel   = s_reg.adc_input[7:5];
   assign ctl.right_boost_en     = s_reg.adc_input[4];
   assign ctl.right_input_gain   = s_reg.adc_input[3:0];
   assign ctl.left_dactwo_mute   = s_reg.dac2_mix[15];
   assign ctl.left_dactwo_level  = s_reg.dac2_mix[12:8];
   assign ctl.right_dactwo_mute  = s_reg.dac2_mix[7];
   assign ctl.right_dactwo_level = s_reg.dac2_mix[4:0];
   assign ctl.left_auxone_mute   = s_reg.aux1_mix[15];
   assign ctl.left_auxone_level  = s_reg.aux1_mix[12:8];
   assign ctl.right_auxone_mute  = s_reg.aux1_mix[7];
   assign ctl.right_auxone_level = s_reg.aux1_mix[4:0];
   assign ctl.left_auxtwo_mute   = s_reg.aux2_mix[15];
   assign ctl.left_auxtwo_level  = s_reg.aux2_mix[12:8];
   assign ctl.right_auxtwo_mute  = s_reg.aux2_mix[7];
   assign ctl.right_auxtwo_level = s_reg.aux2_mix[4:0];

endmodule // cim_regs

// ==== tb/cim_host.sv ====
// host model: avalon master reaching the register bank
`timescale 1ns/1ps
module cim_host
   import cim_pkg::*;
(
   input  wire logic        clk,
   input  wire logic [31:0] avm_readdata,
   input  wire logic        avm_waitrequest,
   output cim_avm_req_s     avm_req
);
   initial avm_req = '0;
   // raise after an edge, hold until waitrequest is seen low
   task automatic xfer(input bit wr, input logic [7:0] addr,
                       input logic [15:0] wd, output logic [15:0] rd);
      @(posedge clk);
      avm_req <= '{read: !wr, write: wr, address: addr,
                   writedata: {16'h0000, wd}, byteenable: 4'hF};
      @(posedge clk);
      while (avm_waitrequest) @(posedge clk);
      rd = avm_readdata[15:0];
      avm_req <= '0;
   endtask
endmodule // cim_host

// ==== tb/cim_regs_props.sv ====
// concurrent checks on the ports of the register bank
`timescale 1ns/1ps
module cim_regs_props
   import cim_pkg::*;
(
   input wire logic             clk,
   input wire logic             nrst,
   input wire logic             power_down_pin_n,
   input wire cim_avm_req_s     avm_req,
   input wire logic [31:0]      avm_readdata,
   input wire logic             avm_waitrequest,
   input wire cim_events_s      events,
   input wire logic [1:0][15:0] dac_sample_out,
   input wire logic             converter_powered_down_flag,
   input wire cim_ctl_s         ctl
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire logic req_on = avm_req.read | avm_req.write;
   ////////////////////////////////////////////////////////////////////////
   a_one_wait_state: assert property (req_on && avm_waitrequest |=>
      !avm_waitrequest) else $error("bus answer late");
   a_idle_ready: assert property (!req_on |-> !avm_waitrequest)
      else $error("wait while idle");
   a_upper_zero: assert property (avm_req.read && !avm_waitrequest |->
      avm_readdata[31:16] == 16'h0000) else $error("upper bits set");
   a_pd_follow: assert property (!power_down_pin_n |=>
      converter_powered_down_flag) else $error("flag not raised");
   a_pd_cause: assert property (
      $rose(converter_powered_down_flag) |->
      $past(!power_down_pin_n) || $past(avm_req.write))
      else $error("flag rose without cause");
   a_dac1_zero: assert property (
      events.dac_req[0] && !events.dac_avail[0] |=>
      dac_sample_out[0] == 16'h0000)
      else $error("dac1 underrun not zero");
   a_dac2_zero: assert property (
      events.dac_req[1] && !events.dac_avail[1] |=>
      dac_sample_out[1] == 16'h0000)
      else $error("dac2 underrun not zero");
   a_dac1_take: assert property (
      events.dac_req[0] && events.dac_avail[0] |=>
      dac_sample_out[0] == $past(events.dac_sample[0]))
      else $error("dac1 sample lost");
   a_held_default: assert property (
      !power_down_pin_n [*3] |->
      ctl.left_source_sel == 3'h0 && ctl.right_input_gain == 4'h0 &&
      ctl.left_dactwo_mute && ctl.right_auxone_level == 5'h08)
      else $error("registers not at default");
   c_write: cover property (avm_req.write && !avm_waitrequest);
   c_underrun: cover property (events.dac_req[0] && !events.dac_avail[0]);
   c_pin_low: cover property (!power_down_pin_n [*3]);
endmodule // cim_regs_props

bind cim_regs cim_regs_props cim_regs_props_inst (.clk(clk), .nrst(nrst),
   .power_down_pin_n(power_down_pin_n), .avm_req(avm_req),
   .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
   .events(events), .dac_sample_out(dac_sample_out),
   .converter_powered_down_flag(converter_powered_down_flag), .ctl(ctl));

// ==== tb/cim_regs_tb_top.sv ====
// self-checking bench of the codec input/mix register bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
   n_errors++; $display("wrong value %s exp %h got %h", nm, exp, got); \
   end end
module cim_regs_tb_top
   import cim_pkg::*;
;
   logic             clk = 1'b0;
   logic             nrst = 1'b0;
   logic             power_down_pin_n = 1'b1;
   cim_avm_req_s     avm_req;
   logic [31:0]      avm_readdata;
   logic             avm_waitrequest;
   cim_events_s      events = '0;
   logic [1:0][15:0] dac_sample_out;
   logic             converter_powered_down_flag;
   cim_ctl_s         ctl;
   int               n_errors = 0;
   int               compares = 0;
   int               uf [0:1];
   int               peak [0:1];
   logic [15:0]      rd;
   logic [15:0]      v;
   always #12.5 clk = ~clk;
   cim_regs cim_regs_inst (.clk(clk), .nrst(nrst),
      .power_down_pin_n(power_down_pin_n), .avm_req(avm_req),
      .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
      .events(events), .dac_sample_out(dac_sample_out),
      .converter_powered_down_flag(converter_powered_down_flag), .ctl(ctl));
   cim_host cim_host_inst (.clk(clk), .avm_readdata(avm_readdata),
      .avm_waitrequest(avm_waitrequest), .avm_req(avm_req));
   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [5:0] idx, input logic [15:0] d);
      cim_host_inst.xfer(1'b1, {idx, 2'b00}, d, rd);
   endtask
   task automatic chk_rd(input logic [5:0] idx, input logic [15:0] e);
      cim_host_inst.xfer(1'b0, {idx, 2'b00}, 16'h0000, rd);
      `CHK("readdata", e, rd)
   endtask
   task automatic ev(input int g, input bit avail, input logic [15:0] s);
      @(posedge clk);
      events.dac_req[g] <= 1'b1;
      events.dac_avail[g] <= avail;
      events.dac_sample[g] <= s;
      @(posedge clk);
      events.dac_req[g] <= 1'b0;
      if (!avail) uf[g] = 1;
      @(posedge clk);
      `CHK("dac out", avail ? s : 16'h0000, dac_sample_out[g])
   endtask
   task automatic pk(input int g, input logic [1:0] c);
      @(posedge clk);
      events.adc_peak_valid[g] <= 1'b1;
      events.adc_peak_code[g] <= c;
      @(posedge clk);
      events.adc_peak_valid[g] <= 1'b0;
      if (c > peak[g]) peak[g] = c;
   endtask
   function automatic logic [15:0] fexp();
      return {6'h00, uf[1][0], uf[0][0], 4'h0, peak[1][1:0], peak[0][1:0]};
   endfunction
   task automatic tally_and_finish();
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #500000;
      n_errors++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'hDDE23991));
      uf = '{0, 0};
      peak = '{0, 0};
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      chk_rd(CIM_IDX_CHANNEL_FLAGS, 16'h0000);
      chk_rd(CIM_IDX_DAC2_MIX, 16'h8888);
      wr(CIM_IDX_ADC_INPUT, 16'hFFFF);
      chk_rd(CIM_IDX_ADC_INPUT, 16'h0000);
      cim_host_inst.xfer(1'b0, 8'h00, 16'h0000, rd);
      `CHK("pd flag", 1'b1, rd[CIM_STAT_PDFLAG])
      wr(CIM_IDX_POWER_CTRL, 16'h0000);
      wr(CIM_IDX_CHANNEL_ENABLE, 16'h007F);
      for (int i = 0; i < 8; i++) begin
         v = 16'($urandom);
         v[15:13] = i[2:0];
         v[7:5] = ~i[2:0];
         wr(CIM_IDX_ADC_INPUT, v);
         chk_rd(CIM_IDX_ADC_INPUT, v);
         `CHK("left src", v[15:13], ctl.left_source_sel)
         `CHK("left boost", v[12], ctl.left_boost_en)
         `CHK("right gain", v[3:0], ctl.right_input_gain)
         for (int r = 3; r < 6; r++) begin
            v = 16'($urandom) & CIM_MIX_WMASK;
            wr(r[5:0], v);
            chk_rd(r[5:0], v);
         end
         `CHK("aux2 level", v[12:8], ctl.left_auxtwo_level)
         `CHK("aux2 mute", v[7], ctl.right_auxtwo_mute)
      end
      wr(CIM_IDX_AUX1_MIX, 16'hFFFF);
      chk_rd(CIM_IDX_AUX1_MIX, 16'h9F9F);
      wr(6'h06, 16'hFFFF);
      chk_rd(6'h06, 16'h0000);
      cim_host_inst.xfer(1'b0, 8'h11, 16'h0000, rd);
      `CHK("misaligned", 16'h0000, rd)
      ev(0, 1'b1, 16'h1234);
      ev(0, 1'b0, 16'h5678);
      ev(1, 1'b0, 16'h0F0F);
      for (int i = 0; i < 10; i++) pk(i % 2, 2'($urandom));
      chk_rd(CIM_IDX_CHANNEL_FLAGS, fexp());
      wr(CIM_IDX_CHANNEL_FLAGS, 16'h0000);
      uf = '{0, 0};
      peak = '{0, 0};
      chk_rd(CIM_IDX_CHANNEL_FLAGS, 16'h0000);
      pk(1, 2'h2);
      pk(1, 2'h1);
      pk(0, 2'h3);
      ev(0, 1'b0, 16'hAAAA);
      chk_rd(CIM_IDX_CHANNEL_FLAGS, fexp());
      wr(CIM_IDX_CHANNEL_ENABLE, 16'h0069);
      uf[0] = 0;
      peak[1] = 0;
      chk_rd(CIM_IDX_CHANNEL_FLAGS, fexp());
      wr(CIM_IDX_DAC2_MIX, 16'h1111);
      chk_rd(CIM_IDX_DAC2_MIX, 16'h8888);
      ev(1, 1'b0, 16'h5555);
      @(posedge clk);
      power_down_pin_n <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK("pd out", 1'b1, converter_powered_down_flag)
      chk_rd(CIM_IDX_CHANNEL_FLAGS, 16'h0000);
      wr(CIM_IDX_ADC_INPUT, 16'h1234);
      chk_rd(CIM_IDX_ADC_INPUT, 16'h0000);
      chk_rd(CIM_IDX_AUX1_MIX, 16'h8888);
      @(posedge clk);
      power_down_pin_n <= 1'b1;
      repeat (3) @(posedge clk);
      cim_host_inst.xfer(1'b0, 8'h00, 16'h0000, rd);
      `CHK("pd flag", 1'b0, rd[CIM_STAT_PDFLAG])
      `CHK("pd out", 1'b0, converter_powered_down_flag)
      tally_and_finish();
   end
endmodule // cim_regs_tb_top
